// ==== verilog/cct_pkg.sv ====
// Purpose: shared constants for the converter register bank
// Assumes: 100 MHz mclk, serial pins sampled synchronously
// Notes:   offsets, resets, field positions and timing counts
package cct_pkg;

  // ************************************************************
  // serial port
  // ************************************************************
  localparam logic [6:0] CCT_SLAVE_ADDR     = 7'h30;
  localparam logic [7:0] CCT_UNMAPPED_DATA  = 8'hff;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] CCT_OFS_SETPOINT   = 8'h00;
  localparam logic [7:0] CCT_OFS_DCR        = 8'h02;
  localparam logic [7:0] CCT_OFS_SOFTSTART  = 8'h03;
  localparam logic [7:0] CCT_OFS_VOUT_LOW   = 8'h42;
  localparam logic [7:0] CCT_OFS_VOUT_HIGH  = 8'h43;
  localparam logic [7:0] CCT_OFS_VIN        = 8'h46;
  localparam logic [7:0] CCT_OFS_IFAST      = 8'h48;
  localparam logic [7:0] CCT_OFS_IPREC_LOW  = 8'h4a;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0]  CCT_RST_SETPOINT  = 8'h46;
  localparam logic [3:0]  CCT_RST_DCR       = 4'h0;
  localparam logic [2:0]  CCT_RST_SOFTSTART = 3'h4;
  localparam logic [7:0]  CCT_RST_RESULT8   = 8'h00;
  localparam logic [11:0] CCT_RST_RESULT12  = 12'h000;
  localparam int          CCT_DCR_LSB       = 4;
  localparam int          CCT_SS_LSB        = 0;
  localparam int          CCT_RESULT_LOW_LSB = 4;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CCT_CLK_PERIOD_PS   = 10000;
  localparam int CCT_PREC_PERIOD_US  = 128;
  localparam int CCT_PREC_PERIOD_CYC = (CCT_PREC_PERIOD_US * 1000000) / CCT_CLK_PERIOD_PS;

  // ************************************************************
  // serial engine states
  // ************************************************************
  typedef enum logic [3:0] {
    CCT_IDLE      = 4'h0,
    CCT_ADDR      = 4'h1,
    CCT_ADDR_ACK  = 4'h2,
    CCT_OFFS      = 4'h3,
    CCT_OFFS_ACK  = 4'h4,
    CCT_WDATA     = 4'h5,
    CCT_WDATA_ACK = 4'h6,
    CCT_RDATA     = 4'h7,
    CCT_RDATA_ACK = 4'h8
  } cct_state_e;

endpackage

// ==== verilog/cct_split_latch.sv ====
// Purpose: holds a 12-bit result frozen until both bytes are read
// Assumes: read strobes are one-cycle pulses
// Notes:   after reset the latch is free to load
`timescale 1ns/1ps
module cct_split_latch (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [11:0] sample_data,
  input  wire logic        sample_valid,
  input  wire logic        rd_low,
  input  wire logic        rd_high,
  output logic      [11:0] held_data
);
  import cct_pkg::*;

  logic [11:0] held_reg;
  logic [11:0] held_next;
  logic        low_rd_reg;
  logic        low_rd_next;
  logic        high_rd_reg;
  logic        high_rd_next;
  logic        free;

  // ************************************************************
  // freeze until consumed
  // ************************************************************
  assign free = low_rd_reg & high_rd_reg;

  always_comb begin
    held_next    = held_reg;
    low_rd_next  = low_rd_reg | rd_low;
    high_rd_next = high_rd_reg | rd_high;
    if (sample_valid && free) begin
      held_next    = sample_data;
      low_rd_next  = 1'b0;
      high_rd_next = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      held_reg    <= CCT_RST_RESULT12;
      low_rd_reg  <= 1'b1;
      high_rd_reg <= 1'b1;
    end else begin
      held_reg    <= held_next;
      low_rd_reg  <= low_rd_next;
      high_rd_reg <= high_rd_next;
    end
  end

  assign held_data = held_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_FROZEN_UNTIL_READ: assert property (
    !free |=> $stable(held_reg) || $past(free))
    else $error("held result changed before both bytes were read");
  AST_LOADS_WHEN_FREE: assert property (
    free && sample_valid |=> held_reg == $past(sample_data) && !free)
    else $error("free latch did not take a new sample");
endmodule

// ==== verilog/cct_tick_gen.sv ====
// Purpose: periodic strobe for the precision current result
// Assumes: period well above one cycle
// Notes:   one-cycle pulse each period
`timescale 1ns/1ps
module cct_tick_gen #(
  parameter int PERIOD_CYC = 12800
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  output logic      tick
);
  import cct_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;

  // ************************************************************
  // period counter
  // ************************************************************
  always_comb begin
    tick_next = (cnt_reg == 16'(PERIOD_CYC - 1));
    cnt_next  = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_TICK_PERIOD: assert property (
    tick |-> cnt_reg == 16'h0000 && $past(cnt_reg) == 16'(PERIOD_CYC - 1))
    else $error("precision tick not at end of period");
endmodule

// ==== verilog/cct_regs.sv ====
// Purpose: converter setting and telemetry registers behind a serial slave
// Assumes: scl/sda sampled on mclk, several mclk per serial half bit
// Notes:   sda is open drain; sda_out is always low when enabled
`timescale 1ns/1ps
module cct_regs #(
  parameter int PREC_PERIOD_CYC = cct_pkg::CCT_PREC_PERIOD_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [11:0] vout_sample,
  input  wire logic        vout_sample_valid,
  input  wire logic [7:0]  vin_sample,
  input  wire logic        vin_sample_valid,
  input  wire logic [7:0]  ifast_sample,
  input  wire logic        ifast_sample_valid,
  input  wire logic [11:0] iprec_sample,
  output logic             iprec_sample_strobe,
  output logic [7:0]       output_voltage_setpoint,
  output logic [3:0]       inductor_resistance_code,
  output logic [2:0]       soft_start_code
);
  import cct_pkg::*;

  cct_state_e  state_reg;
  cct_state_e  state_next;
  logic [3:0]  cnt_reg;
  logic [3:0]  cnt_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic [7:0]  ptr_reg;
  logic [7:0]  ptr_next;
  logic        rw_reg;
  logic        rw_next;
  logic        nack_reg;
  logic        nack_next;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        wr_fire;
  logic        rd_fire;
  logic [7:0]  read_data;
  logic [7:0]  setpoint_reg;
  logic [7:0]  setpoint_next;
  logic [3:0]  dcr_reg;
  logic [3:0]  dcr_next;
  logic [2:0]  ss_reg;
  logic [2:0]  ss_next;
  logic [7:0]  vin_reg;
  logic [7:0]  vin_next;
  logic [7:0]  ifast_reg;
  logic [7:0]  ifast_next;
  logic [11:0] vout_held;
  logic [11:0] iprec_held;
  logic        prec_tick;

  // ************************************************************
  // pin edge detection
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  assign scl_rise  = scl_in & ~scl_prev_reg;
  assign scl_fall  = ~scl_in & scl_prev_reg;
  assign bus_start = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  assign bus_stop  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;

  // ************************************************************
  // serial engine
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    rw_next    = rw_reg;
    nack_next  = nack_reg;
    wr_fire    = 1'b0;
    rd_fire    = 1'b0;
    if (bus_start) begin
      state_next = CCT_ADDR;
      cnt_next   = 4'h0;
    end else if (bus_stop) begin
      state_next = CCT_IDLE;
    end else begin
      case (state_reg)
        CCT_ADDR, CCT_OFFS, CCT_WDATA: begin
          if (scl_rise && cnt_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda_in};
            cnt_next   = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (state_reg == CCT_ADDR) begin
              rw_next    = shift_reg[0];
              state_next = (shift_reg[7:1] == CCT_SLAVE_ADDR) ? CCT_ADDR_ACK
                                                               : CCT_IDLE;
            end else if (state_reg == CCT_OFFS) begin
              ptr_next   = shift_reg;
              state_next = CCT_OFFS_ACK;
            end else begin
              state_next = CCT_WDATA_ACK;
            end
          end
        end
        CCT_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              rd_fire    = 1'b1;
              shift_next = read_data;
              ptr_next   = ptr_reg + 8'h01;
              state_next = CCT_RDATA;
            end else begin
              state_next = CCT_OFFS;
            end
          end
        end
        CCT_OFFS_ACK: begin
          if (scl_fall) begin
            state_next = CCT_WDATA;
          end
        end
        CCT_WDATA_ACK: begin
          if (scl_fall) begin
            wr_fire    = 1'b1;
            ptr_next   = ptr_reg + 8'h01;
            state_next = CCT_WDATA;
          end
        end
        CCT_RDATA: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              state_next = CCT_RDATA_ACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b1};
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        CCT_RDATA_ACK: begin
          if (scl_rise) begin
            nack_next = sda_in;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if (nack_reg) begin
              state_next = CCT_IDLE;
            end else begin
              rd_fire    = 1'b1;
              shift_next = read_data;
              ptr_next   = ptr_reg + 8'h01;
              state_next = CCT_RDATA;
            end
          end
        end
        default: begin
          state_next = CCT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= CCT_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      rw_reg    <= 1'b0;
      nack_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      rw_reg    <= rw_next;
      nack_reg  <= nack_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = (state_reg == CCT_ADDR_ACK) || (state_reg == CCT_OFFS_ACK) ||
                   (state_reg == CCT_WDATA_ACK) ||
                   (state_reg == CCT_RDATA && !shift_reg[7]);

  // ************************************************************
  // read map
  // ************************************************************
  always_comb begin
    case (ptr_reg)
      CCT_OFS_SETPOINT:  read_data = setpoint_reg;
      CCT_OFS_DCR:       read_data = {dcr_reg, 4'h0};
      CCT_OFS_SOFTSTART: read_data = {5'h00, ss_reg};
      CCT_OFS_VOUT_LOW:  read_data = {vout_held[3:0], 4'h0};
      CCT_OFS_VOUT_HIGH: read_data = vout_held[11:4];
      CCT_OFS_VIN:       read_data = vin_reg;
      CCT_OFS_IFAST:     read_data = ifast_reg;
      CCT_OFS_IPREC_LOW: read_data = {iprec_held[3:0], 4'h0};
      default:           read_data = CCT_UNMAPPED_DATA;
    endcase
  end

  // ************************************************************
  // settings and fast results
  // ************************************************************
  always_comb begin
    setpoint_next = setpoint_reg;
    dcr_next      = dcr_reg;
    ss_next       = ss_reg;
    vin_next      = vin_sample_valid ? vin_sample : vin_reg;
    ifast_next    = ifast_sample_valid ? ifast_sample : ifast_reg;
    if (wr_fire) begin
      case (ptr_reg)
        CCT_OFS_SETPOINT:  setpoint_next = shift_reg;
        CCT_OFS_DCR:       dcr_next = shift_reg[CCT_DCR_LSB +: 4];
        CCT_OFS_SOFTSTART: ss_next = shift_reg[CCT_SS_LSB +: 3];
        default:           setpoint_next = setpoint_reg;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      setpoint_reg <= CCT_RST_SETPOINT;
      dcr_reg      <= CCT_RST_DCR;
      ss_reg       <= CCT_RST_SOFTSTART;
      vin_reg      <= CCT_RST_RESULT8;
      ifast_reg    <= CCT_RST_RESULT8;
    end else begin
      setpoint_reg <= setpoint_next;
      dcr_reg      <= dcr_next;
      ss_reg       <= ss_next;
      vin_reg      <= vin_next;
      ifast_reg    <= ifast_next;
    end
  end

  assign output_voltage_setpoint  = setpoint_reg;
  assign inductor_resistance_code = dcr_reg;
  assign soft_start_code          = ss_reg;

  // ************************************************************
  // split results
  // ************************************************************
  cct_split_latch u_vout_latch (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_data  (vout_sample),
    .sample_valid (vout_sample_valid),
    .rd_low       (rd_fire && ptr_reg == CCT_OFS_VOUT_LOW),
    .rd_high      (rd_fire && ptr_reg == CCT_OFS_VOUT_HIGH),
    .held_data    (vout_held)
  );

  cct_tick_gen #(
    .PERIOD_CYC (PREC_PERIOD_CYC)
  ) u_prec_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .tick    (prec_tick)
  );

  cct_split_latch u_iprec_latch (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .sample_data  (iprec_sample),
    .sample_valid (prec_tick),
    .rd_low       (rd_fire && ptr_reg == CCT_OFS_IPREC_LOW),
    .rd_high      (rd_fire && ptr_reg == CCT_OFS_IPREC_LOW),
    .held_data    (iprec_held)
  );

  assign iprec_sample_strobe = prec_tick;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_byte_in_done;
    (state_reg == CCT_OFFS || state_reg == CCT_WDATA) && scl_fall && cnt_reg == 4'h8
      && !bus_start && !bus_stop;
  endsequence
  sequence s_addr_miss;
    state_reg == CCT_ADDR && scl_fall && cnt_reg == 4'h8 && !bus_start && !bus_stop
      && shift_reg[7:1] != CCT_SLAVE_ADDR;
  endsequence

  AST_RESET_VALUES: assert property (
    $fell(sys_rst) |-> setpoint_reg == CCT_RST_SETPOINT && dcr_reg == CCT_RST_DCR
      && ss_reg == CCT_RST_SOFTSTART && vin_reg == CCT_RST_RESULT8
      && ifast_reg == CCT_RST_RESULT8)
    else $error("wrong register values after reset");
  AST_ACK_DRIVEN: assert property (
    s_byte_in_done |=> sda_oe)
    else $error("received byte not acknowledged");
  AST_ADDR_IGNORED: assert property (
    s_addr_miss |=> state_reg == CCT_IDLE ##1 !sda_oe)
    else $error("foreign address was answered");
  AST_SETPOINT_WRITE: assert property (
    wr_fire && ptr_reg == CCT_OFS_SETPOINT |=> setpoint_reg == $past(shift_reg))
    else $error("setpoint write not applied");
  AST_DCR_WRITE: assert property (
    wr_fire && ptr_reg == CCT_OFS_DCR |=> dcr_reg == $past(shift_reg[7:4]))
    else $error("resistance code write not applied");
  AST_SS_WRITE: assert property (
    wr_fire && ptr_reg == CCT_OFS_SOFTSTART |=> ss_reg == $past(shift_reg[2:0]))
    else $error("slew code write not applied");
  AST_RO_IGNORED: assert property (
    wr_fire && ptr_reg != CCT_OFS_SETPOINT && ptr_reg != CCT_OFS_DCR
      && ptr_reg != CCT_OFS_SOFTSTART
      |=> $stable(setpoint_reg) && $stable(dcr_reg) && $stable(ss_reg))
    else $error("write to read-only offset changed a setting");
  AST_UNMAPPED_READ: assert property (
    rd_fire && ptr_reg == 8'h01 |=> shift_reg == 8'hff)
    else $error("unmapped read did not return all ones");
  AST_VOUT_HIGH_READ: assert property (
    rd_fire && ptr_reg == CCT_OFS_VOUT_HIGH |=> shift_reg == $past(vout_held[11:4]))
    else $error("output voltage high byte wrong");
  AST_VIN_LOAD: assert property (
    vin_sample_valid |=> vin_reg == $past(vin_sample))
    else $error("input voltage result not loaded");
  AST_IFAST_LOAD: assert property (
    ifast_sample_valid |=> ifast_reg == $past(ifast_sample))
    else $error("fast current result not loaded");
endmodule

// ==== testbench/cct_host_model.sv ====
// Purpose: serial host model driving the register bank pins
// Assumes: sda resolved outside with a pull-up
// Notes:   half bit of four mclk cycles, changes 1 ns after the edge
`timescale 1ns/1ps
module cct_host_model (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl_line,
  output logic      sda_pull
);
  // ****************************************
  // bit level
  // ****************************************
  initial begin
    scl_line = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic step();
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task automatic put_bit(input logic b);
    sda_pull = ~b;
    step();
    scl_line = 1'b1;
    step();
    scl_line = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    sda_pull = 1'b0;
    step();
    scl_line = 1'b1;
    step();
    b = sda_line;
    scl_line = 1'b0;
  endtask
  task automatic start();
    sda_pull = 1'b0;
    step();
    scl_line = 1'b1;
    step();
    sda_pull = 1'b1;
    step();
    scl_line = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    step();
    scl_line = 1'b1;
    step();
    sda_pull = 1'b0;
    step();
  endtask
  // ****************************************
  // byte and transfer level
  // ****************************************
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ack = ~a;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask
  // scaling of readings into amperes is left to host software
  task automatic wr(input logic [6:0] sa, input logic [7:0] o, input logic [7:0] d,
                    output logic ack);
    logic a1;
    logic a2;
    start();
    put_byte({sa, 1'b0}, ack);
    if (ack) begin
      put_byte(o, a1);
      put_byte(d, a2);
      ack = a1 & a2;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] o, output logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    put_byte(8'h60, a0);
    put_byte(o, a1);
    start();
    put_byte(8'h61, a2);
    get_byte(d, 1'b1);
    stop();
    ack = a0 & a1 & a2;
  endtask
  // two-byte read: host acks the first byte, nacks the second
  task automatic rd2(input logic [7:0] o, output logic [15:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start();
    put_byte(8'h60, a0);
    put_byte(o, a1);
    start();
    put_byte(8'h61, a2);
    get_byte(d[15:8], 1'b0);
    get_byte(d[7:0], 1'b1);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

// ==== testbench/cct_regs_bench.sv ====
// Purpose: self-checking bench for the converter register bank
// Assumes: host model on the serial pins, short precision period
// Notes:   read-value model compared at every read and write
`timescale 1ns/1ps
module cct_regs_bench;
  import cct_pkg::*;
  localparam int PREC = 50;
  logic        mclk, sys_rst, scl_line, sda_pull, sda_line, sda_out, sda_oe;
  logic        vout_sample_valid, vin_sample_valid, ifast_sample_valid, iprec_sample_strobe;
  logic [11:0] vout_sample, iprec_sample;
  logic [7:0]  vin_sample, ifast_sample, output_voltage_setpoint, d;
  logic [15:0] w;
  logic [3:0]  inductor_resistance_code;
  logic [2:0]  soft_start_code;
  logic [7:0]  m [256];
  logic [7:0]  ofs_list [12];
  int          error_cnt, num_checks, seed, cyc, last_tick;
  bit          vfree, vrl, vrh;

  assign sda_line = ~sda_pull & ~(sda_oe & ~sda_out);
  cct_regs #(.PREC_PERIOD_CYC(PREC)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .vout_sample(vout_sample),
    .vout_sample_valid(vout_sample_valid), .vin_sample(vin_sample),
    .vin_sample_valid(vin_sample_valid), .ifast_sample(ifast_sample),
    .ifast_sample_valid(ifast_sample_valid), .iprec_sample(iprec_sample),
    .iprec_sample_strobe(iprec_sample_strobe),
    .output_voltage_setpoint(output_voltage_setpoint),
    .inductor_resistance_code(inductor_resistance_code), .soft_start_code(soft_start_code));
  cct_host_model host (.mclk(mclk), .sda_line(sda_line), .scl_line(scl_line),
    .sda_pull(sda_pull));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic report_and_stop();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_ports();
    chk("setpoint", m[0], output_voltage_setpoint);
    chk("dcr", {4'h0, m[2][7:4]}, {4'h0, inductor_resistance_code});
    chk("slew", m[3], {5'h00, soft_start_code});
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (16) @(posedge mclk);
    #1;
    sys_rst = 1'b0;
    foreach (m[i]) begin
      m[i] = (i inside {2, 3, 'h42, 'h43, 'h46, 'h48, 'h4a}) ? 8'h00 : 8'hff;
    end
    m[0] = 8'h46;
    m[3] = 8'h04;
    vfree = 1'b1;
    vrl = 1'b0;
    vrh = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] o);
    logic [7:0] rv;
    logic       ack;
    host.rd(o, rv, ack);
    chk("read ack", 8'h01, {7'h00, ack});
    chk($sformatf("read %h", o), m[o], rv);
    vrl = vrl | (o == 8'h42);
    vrh = vrh | (o == 8'h43);
    vfree = vfree | (vrl & vrh);
  endtask
  task automatic wr_chk(input logic [7:0] o, input logic [7:0] v);
    logic ack;
    host.wr(7'h30, o, v, ack);
    chk("write ack", 8'h01, {7'h00, ack});
    case (o)
      8'h00: m[o] = v;
      8'h02: m[o] = v & 8'hf0;
      8'h03: m[o] = v & 8'h07;
      default: ;
    endcase
    chk_ports();
  endtask
  task automatic pulse();
    vout_sample = 12'($random(seed));
    vin_sample = 8'($random(seed));
    ifast_sample = 8'($random(seed));
    {vout_sample_valid, vin_sample_valid, ifast_sample_valid} = 3'h7;
    if (vfree) begin
      m[8'h42] = {vout_sample[3:0], 4'h0};
      m[8'h43] = vout_sample[11:4];
      vfree = 1'b0;
      vrl = 1'b0;
      vrh = 1'b0;
    end
    m[8'h46] = vin_sample;
    m[8'h48] = ifast_sample;
    @(posedge mclk);
    #1;
    {vout_sample_valid, vin_sample_valid, ifast_sample_valid} = 3'h0;
    vout_sample = ~vout_sample;
  endtask

  // ****************************************
  // clock, timeout and strobe spacing
  // ****************************************
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(negedge mclk) begin
    cyc++;
    if (sys_rst) begin
      last_tick = cyc + 1;
    end else if (iprec_sample_strobe === 1'b1) begin
      chk("tick gap", 8'(PREC), 8'(cyc - last_tick));
      last_tick = cyc;
    end
    if (cyc == 60000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    seed = 23828;
    sys_rst = 1'b1;
    {vout_sample_valid, vin_sample_valid, ifast_sample_valid} = 3'h0;
    vout_sample = 12'h000;
    vin_sample = 8'h00;
    ifast_sample = 8'h00;
    iprec_sample = 12'h000;
    ofs_list = '{8'h00, 8'h02, 8'h03, 8'h01, 8'h42, 8'h43, 8'h46, 8'h48, 8'h4a, 8'h04, 8'h4b,
                 8'hff};
    do_reset();
    chk_ports();
    foreach (ofs_list[i]) begin
      if (ofs_list[i] != 8'h4a) begin
        rd_chk(ofs_list[i]);
      end
    end
    iprec_sample = 12'($random(seed));
    rd_chk(8'h4a);
    repeat (2 * PREC) @(posedge mclk);
    #1;
    m[8'h4a] = {iprec_sample[3:0], 4'h0};
    iprec_sample = 12'($random(seed));
    rd_chk(8'h4a);
    repeat (2 * PREC) @(posedge mclk);
    #1;
    m[8'h4a] = {iprec_sample[3:0], 4'h0};
    rd_chk(8'h4a);
    pulse();
    rd_chk(8'h42);
    pulse();
    rd_chk(8'h43);
    rd_chk(8'h46);
    rd_chk(8'h48);
    pulse();
    rd_chk(8'h43);
    rd_chk(8'h42);
    pulse();
    host.rd2(8'h42, w, d[0]);
    chk("burst ack", 8'h01, {7'h00, d[0]});
    chk("burst low", m[8'h42], w[15:8]);
    chk("burst high", m[8'h43], w[7:0]);
    host.wr(7'h31, 8'h00, 8'h12, d[0]);
    chk("foreign address ack", 8'h00, {7'h00, d[0]});
    chk_ports();
    repeat (2) begin
      foreach (ofs_list[i]) begin
        d = (ofs_list[i] == 8'h00) ? 8'({$random(seed)} % 181) : 8'($random(seed));
        wr_chk(ofs_list[i], d);
        rd_chk(ofs_list[i]);
      end
    end
    do_reset();
    chk_ports();
    rd_chk(8'h00);
    report_and_stop();
  end
endmodule
